// ===== rtl/mrfd_field_decode.sv
// decodes one margining byte into millivolt settings
// assumes target voltage in mV, unsigned, below 4096
module mrfd_field_decode (
   // stored register and target
   input wire logic [7:0] margin_ctrl_any,
   input wire logic [11:0] nominal_target_voltage,
   // decoded settings
   output logic [11:0] ov_trip_mv,
   output logic [11:0] pg_upper_mv,
   output logic [11:0] pg_lower_mv,
   output logic [11:0] pg_hyst_mv,
   output logic signed [12:0] offset_mv
);
   wire logic ov_hi_sel;
   wire logic pg_wide_sel;
   wire logic signed [5:0] ofs_code;
   wire logic [11:0] ov_sum;
   assign ov_hi_sel = margin_ctrl_any[mrfd_pkg::OV_SEL_BIT];
   assign ov_sum = nominal_target_voltage + (ov_hi_sel ?
      mrfd_pkg::OV_ADD_HI_MV : mrfd_pkg::OV_ADD_LO_MV);
   assign ov_trip_mv = (ov_sum > mrfd_pkg::OV_FLOOR_MV) ? ov_sum :
      mrfd_pkg::OV_FLOOR_MV;
   assign pg_wide_sel = margin_ctrl_any[mrfd_pkg::PG_SEL_BIT];
   assign pg_upper_mv = nominal_target_voltage + (pg_wide_sel ?
      mrfd_pkg::PG_UP_HI_MV : mrfd_pkg::PG_UP_LO_MV);
   // lower bound clamps at zero rather than wrapping
   assign pg_lower_mv = (nominal_target_voltage > (pg_wide_sel ?
      mrfd_pkg::PG_DN_HI_MV : mrfd_pkg::PG_DN_LO_MV)) ?
      nominal_target_voltage - (pg_wide_sel ?
      mrfd_pkg::PG_DN_HI_MV : mrfd_pkg::PG_DN_LO_MV) : 12'h000;
   assign pg_hyst_mv = mrfd_pkg::PG_HYST_MV;
   assign ofs_code = margin_ctrl_any[mrfd_pkg::OFS_MSB:0];
   assign offset_mv = 13'(ofs_code) * $signed(13'(mrfd_pkg::OFS_STEP_MV));
endmodule

// ===== rtl/mrfd_margin_regs.sv
// two margining registers with byte port and per-output decode
// assumes the serial slave presents address/data with one-cycle strobes
// Behaviour
// - both registers share one layout, decoded by one module
// - bit 7 picks overvoltage trip: max(1.8V, target+250 or +500mV)
// - bit 6 picks power-good window +250/-300 or +300/-350 mV
// - every power-good trip point has 50 mV hysteresis
// - bits 5:0 offset the output from its own nominal target
// - offset is two's complement, 25 mV step, -800 to +775 mV
// - address 00 is northbridge register, 01 is core register
// - both registers clear to zero at power-on reset
module mrfd_margin_regs (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // register port from serial slave
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic addr_ok,
   // nominal targets per output
   input wire logic [11:0] nb_target_mv,
   input wire logic [11:0] core_target_mv,
   // northbridge settings
   output logic [11:0] nb_ov_trip_mv,
   output logic [11:0] nb_pg_upper_mv,
   output logic [11:0] nb_pg_lower_mv,
   output logic [11:0] nb_pg_hyst_mv,
   output logic signed [12:0] nb_offset_mv,
   // core settings
   output logic [11:0] core_ov_trip_mv,
   output logic [11:0] core_pg_upper_mv,
   output logic [11:0] core_pg_lower_mv,
   output logic [11:0] core_pg_hyst_mv,
   output logic signed [12:0] core_offset_mv
);
   logic [7:0] northbridge_margin_ctrl;
   logic [7:0] core_margin_ctrl;
   wire logic sel_nb;
   wire logic sel_core;
   wire logic [7:0] next_rd_data;
   wire logic [11:0] d_nb_ov, d_nb_up, d_nb_lo, d_nb_hy;
   wire logic [11:0] d_co_ov, d_co_up, d_co_lo, d_co_hy;
   wire logic signed [12:0] d_nb_of, d_co_of;

   assign sel_nb = reg_addr == mrfd_pkg::NB_ADDR;
   assign sel_core = reg_addr == mrfd_pkg::CORE_ADDR;
   assign next_rd_data = sel_nb ? northbridge_margin_ctrl :
      (sel_core ? core_margin_ctrl : 8'h00);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         northbridge_margin_ctrl <= mrfd_pkg::REG_RESET;
         core_margin_ctrl <= mrfd_pkg::REG_RESET;
      end else if (wr_en) begin
         if (sel_nb) northbridge_margin_ctrl <= wr_data;
         if (sel_core) core_margin_ctrl <= wr_data;
      end
   end

   // read data holds until the next read; unmapped reads give zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         addr_ok <= 1'b0;
      end else begin
         if (rd_en) rd_data <= next_rd_data;
         addr_ok <= sel_nb | sel_core;
      end
   end

   mrfd_field_decode u_nb (
      .margin_ctrl_any(northbridge_margin_ctrl),
      .nominal_target_voltage(nb_target_mv),
      .ov_trip_mv(d_nb_ov),
      .pg_upper_mv(d_nb_up),
      .pg_lower_mv(d_nb_lo),
      .pg_hyst_mv(d_nb_hy),
      .offset_mv(d_nb_of)
   );
   mrfd_field_decode u_core (
      .margin_ctrl_any(core_margin_ctrl),
      .nominal_target_voltage(core_target_mv),
      .ov_trip_mv(d_co_ov),
      .pg_upper_mv(d_co_up),
      .pg_lower_mv(d_co_lo),
      .pg_hyst_mv(d_co_hy),
      .offset_mv(d_co_of)
   );

   // settings retimed every cycle, no hold-off
   // each offset tied to its own output target
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nb_ov_trip_mv <= 12'h000;
         nb_pg_upper_mv <= 12'h000;
         nb_pg_lower_mv <= 12'h000;
         nb_pg_hyst_mv <= 12'h000;
         nb_offset_mv <= 13'sh0;
         core_ov_trip_mv <= 12'h000;
         core_pg_upper_mv <= 12'h000;
         core_pg_lower_mv <= 12'h000;
         core_pg_hyst_mv <= 12'h000;
         core_offset_mv <= 13'sh0;
      end else begin
         nb_ov_trip_mv <= d_nb_ov;
         nb_pg_upper_mv <= d_nb_up;
         nb_pg_lower_mv <= d_nb_lo;
         nb_pg_hyst_mv <= d_nb_hy;
         nb_offset_mv <= d_nb_of;
         core_ov_trip_mv <= d_co_ov;
         core_pg_upper_mv <= d_co_up;
         core_pg_lower_mv <= d_co_lo;
         core_pg_hyst_mv <= d_co_hy;
         core_offset_mv <= d_co_of;
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_nb_write_store: assert property (
      wr_en && reg_addr == 8'h00 |=> northbridge_margin_ctrl == $past(wr_data))
      else $error("northbridge register not written");
   a_core_write_store: assert property (
      wr_en && reg_addr == 8'h01 |=> core_margin_ctrl == $past(wr_data))
      else $error("core register not written");
   a_no_stray_write: assert property (
      !(wr_en && reg_addr == 8'h00) |=> $stable(northbridge_margin_ctrl))
      else $error("northbridge register changed without write");
   a_ov_trip_level: assert property (
      $past(rst_n) |-> nb_ov_trip_mv >= 12'd1800 &&
      nb_ov_trip_mv >= $past(nb_target_mv) +
      ($past(northbridge_margin_ctrl[7]) ? 12'd500 : 12'd250) &&
      (nb_ov_trip_mv == 12'd1800 || nb_ov_trip_mv == $past(nb_target_mv)
      + ($past(northbridge_margin_ctrl[7]) ? 12'd500 : 12'd250)))
      else $error("overvoltage trip wrong");
   a_core_ov_trip: assert property (
      $past(rst_n) |-> core_ov_trip_mv >= 12'd1800 &&
      core_ov_trip_mv >= $past(core_target_mv) +
      ($past(core_margin_ctrl[7]) ? 12'd500 : 12'd250) &&
      (core_ov_trip_mv == 12'd1800 || core_ov_trip_mv ==
      $past(core_target_mv) + ($past(core_margin_ctrl[7]) ? 12'd500 :
      12'd250)))
      else $error("core overvoltage trip wrong");
   a_pg_upper_win: assert property (
      $past(rst_n) |-> core_pg_upper_mv == $past(core_target_mv)
      + ($past(core_margin_ctrl[6]) ? 12'd300 : 12'd250))
      else $error("power-good upper bound wrong");
   a_nb_pg_upper: assert property (
      $past(rst_n) |-> nb_pg_upper_mv == $past(nb_target_mv)
      + ($past(northbridge_margin_ctrl[6]) ? 12'd300 : 12'd250))
      else $error("northbridge power-good upper bound wrong");
   a_pg_lower_win: assert property (
      $past(rst_n) && $past(core_target_mv) >= 12'd400 |->
      core_pg_lower_mv == $past(core_target_mv) -
      ($past(core_margin_ctrl[6]) ? 12'd350 : 12'd300))
      else $error("power-good lower bound wrong");
   a_nb_pg_lower: assert property (
      $past(rst_n) && $past(nb_target_mv) >= 12'd400 |->
      nb_pg_lower_mv == $past(nb_target_mv) -
      ($past(northbridge_margin_ctrl[6]) ? 12'd350 : 12'd300))
      else $error("northbridge power-good lower bound wrong");
   a_pg_hyst_fixed: assert property (
      $past(rst_n) |-> nb_pg_hyst_mv == 12'd50 && core_pg_hyst_mv == 12'd50)
      else $error("hysteresis not 50 mV");
   a_offset_step: assert property (
      $past(rst_n) |-> nb_offset_mv ==
      $signed($past(northbridge_margin_ctrl[5:0])) * 25)
      else $error("offset step wrong");
   a_core_offset_own: assert property (
      $past(rst_n) |-> core_offset_mv ==
      $signed($past(core_margin_ctrl[5:0])) * 25)
      else $error("core offset not from its own register");
   a_offset_ends: assert property (
      $past(rst_n) && $past(core_margin_ctrl[5:0]) == 6'h20 |->
      core_offset_mv == -13'sd800)
      else $error("most negative offset wrong");
   a_offset_top: assert property (
      $past(rst_n) && $past(core_margin_ctrl[5:0]) == 6'h1F |->
      core_offset_mv == 13'sd775)
      else $error("most positive offset wrong");
   a_write_follow: assert property (
      wr_en && reg_addr == 8'h01 ##1 1'b1 |=>
      core_offset_mv == $signed($past(wr_data[5:0], 2)) * 25)
      else $error("core offset did not follow write");
   a_reset_zero: assert property (
      $rose(rst_n) |-> northbridge_margin_ctrl == 8'h00 &&
      core_margin_ctrl == 8'h00)
      else $error("register not cleared");
   a_core_no_stray: assert property (
      !(wr_en && reg_addr == 8'h01) |=> $stable(core_margin_ctrl))
      else $error("core register changed without write");
   a_read_nb_data: assert property (
      rd_en && reg_addr == 8'h00 |=>
      rd_data == $past(northbridge_margin_ctrl))
      else $error("northbridge read data wrong");
   a_read_core_data: assert property (
      rd_en && reg_addr == 8'h01 |=> rd_data == $past(core_margin_ctrl))
      else $error("core read data wrong");
   a_read_unmapped: assert property (
      rd_en && !(reg_addr inside {8'h00, 8'h01}) |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   a_read_hold: assert property (
      !rd_en |=> $stable(rd_data))
      else $error("read data moved without read");
   a_addr_flag: assert property (
      $past(rst_n) |-> addr_ok ==
      ($past(reg_addr) == 8'h00 || $past(reg_addr) == 8'h01))
      else $error("address flag wrong");
   a_nb_write_follow: assert property (
      wr_en && reg_addr == 8'h00 ##1 1'b1 |=>
      nb_offset_mv == $signed($past(wr_data[5:0], 2)) * 25)
      else $error("northbridge offset did not follow write");

   c_nb_write: cover property (wr_en && sel_nb);
   c_core_write: cover property (wr_en && sel_core);
   c_min_offset: cover property (core_margin_ctrl[5:0] == 6'h20);
   c_read_back: cover property (rd_en && sel_core);
   c_wide_limits: cover property (core_margin_ctrl[7:6] == 2'b11);
endmodule

// ===== rtl/mrfd_pkg.sv
// package for the margining register decoder
// assumes millivolt units everywhere for voltage figures
package mrfd_pkg;
   localparam int unsigned REG_W = 8;
   localparam logic [7:0] NB_ADDR = 8'h00;
   localparam logic [7:0] CORE_ADDR = 8'h01;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int unsigned OV_SEL_BIT = 7;
   localparam int unsigned PG_SEL_BIT = 6;
   localparam int unsigned OFS_MSB = 5;
   localparam int unsigned OFS_W = 6;
   // millivolt figures
   localparam logic [11:0] OV_FLOOR_MV = 12'h708;
   localparam logic [11:0] OV_ADD_LO_MV = 12'h0FA;
   localparam logic [11:0] OV_ADD_HI_MV = 12'h1F4;
   localparam logic [11:0] PG_UP_LO_MV = 12'h0FA;
   localparam logic [11:0] PG_DN_LO_MV = 12'h12C;
   localparam logic [11:0] PG_UP_HI_MV = 12'h12C;
   localparam logic [11:0] PG_DN_HI_MV = 12'h15E;
   localparam logic [11:0] PG_HYST_MV = 12'h032;
   localparam logic [11:0] OFS_STEP_MV = 12'h019;
endpackage

// ===== tb/mrfd_host_model.sv
// serial master stand-in driving the byte port
// assumes the bench clock and tasks called from tb
module mrfd_host_model (
   // clock
   input wire logic clk,
   // register port
   output logic wr_en,
   output logic rd_en,
   output logic [7:0] reg_addr,
   output logic [7:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      wr_en = 1'b0;
      rd_en = 1'b0;
      reg_addr = 8'h00;
      wr_data = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      reg_addr <= a;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      rd_en <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
endmodule

// ===== tb/tb.sv
// self-checking bench for the margining registers
// assumes the host model as the only register master
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] nb_t = 12'h3E8;
   logic [11:0] co_t = 12'h640;
   logic we, re, ok;
   logic [7:0] ad, wd, rdd;
   logic [11:0] n_ov, n_up, n_lo, n_hy, c_ov, c_up, c_lo, c_hy;
   logic signed [12:0] n_of, c_of;
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   logic [7:0] codes [4] = '{8'h20, 8'h1F, 8'h3F, 8'h01};
   always #5 clk = ~clk;
   mrfd_host_model HOST (.clk(clk), .wr_en(we), .rd_en(re),
      .reg_addr(ad), .wr_data(wd));
   mrfd_margin_regs DUT (.clk(clk), .rst_n(rst_n), .wr_en(we),
      .rd_en(re), .reg_addr(ad), .wr_data(wd), .rd_data(rdd),
      .addr_ok(ok), .nb_target_mv(nb_t), .core_target_mv(co_t),
      .nb_ov_trip_mv(n_ov), .nb_pg_upper_mv(n_up),
      .nb_pg_lower_mv(n_lo), .nb_pg_hyst_mv(n_hy), .nb_offset_mv(n_of),
      .core_ov_trip_mv(c_ov), .core_pg_upper_mv(c_up),
      .core_pg_lower_mv(c_lo), .core_pg_hyst_mv(c_hy),
      .core_offset_mv(c_of));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic results;
      $display("checks %0d errors %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // hang guard, run needs well under 1000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         results();
      end
   end
   function automatic logic [15:0] ofs_mv(input logic [7:0] c);
      int v;
      v = c[5] ? int'(c[5:0]) - 64 : int'(c[5:0]);
      return 16'(v * 25);
   endfunction
   task automatic settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic t_reset;
      settle();
      chk(n_of, 16'h0000);
      chk(n_ov, 16'h0708);
      chk(c_ov, 16'h073A);
      chk(n_hy, 16'h0032);
      chk(c_hy, 16'h0032);
      HOST.rd(8'h01);
      #1;
      chk(rdd, 16'h0000);
   endtask
   task automatic t_offset;
      for (int i = 0; i < 4; i++) begin
         HOST.wr(8'h00, codes[i]);
         HOST.wr(8'h01, codes[3 - i]);
         settle();
         chk(n_of, ofs_mv(codes[i]));
         chk(c_of, ofs_mv(codes[3 - i]));
      end
   endtask
   task automatic t_bits;
      HOST.wr(8'h01, 8'hC0);
      settle();
      chk(c_ov, 16'h0834);
      chk(c_up, 16'h076C);
      chk(c_lo, 16'h04E2);
      chk(c_hy, 16'h0032);
      chk(n_up, 16'h04E2);
      chk(n_lo, 16'h02BC);
      HOST.wr(8'h00, 8'hC0);
      settle();
      chk(n_ov, 16'h0708);
      chk(n_up, 16'h0514);
      chk(n_lo, 16'h028A);
   endtask
   task automatic t_regs;
      HOST.wr(8'h00, 8'h5A);
      HOST.wr(8'h01, 8'hA5);
      HOST.wr(8'h02, 8'hFF);
      HOST.rd(8'h00);
      #1;
      chk(rdd, 16'h005A);
      chk(ok, 16'h0001);
      HOST.rd(8'h01);
      #1;
      chk(rdd, 16'h00A5);
      HOST.rd(8'h02);
      #1;
      chk({rdd, 7'h00, ok}, 16'h0000);
      @(posedge clk) nb_t <= 12'h7D0;
      settle();
      chk(n_ov, 16'h08CA);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      HOST.rd(8'h00);
      #1;
      chk(rdd, 16'h0000);
      settle();
      chk(n_of, 16'h0000);
      chk(c_of, 16'h0000);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_offset();
      t_bits();
      t_regs();
      results();
   end
endmodule
